//--- verilog/dsbs_pkg.sv
// Purpose: shared constants and types for the saturate / bit-set / status datapath
// Assumes: 40-bit accumulators, 16-bit auxiliary registers and status words
// Notes: register offsets are word aligned APB byte addresses
package dsbs_pkg;
  // ==========================================
  // widths
  localparam int ACC_W = 40;
  localparam int AUX_W = 16;
  localparam int ST_W = 16;
  // ==========================================
  // apb map
  localparam logic [7:0] OFS_ST0 = 8'h00;
  localparam logic [7:0] OFS_ST1 = 8'h04;
  localparam logic [7:0] OFS_ST2 = 8'h08;
  localparam logic [7:0] OFS_ST3 = 8'h0C;
  localparam logic [7:0] OFS_ST0P = 8'h10;
  localparam logic [7:0] OFS_ST1P = 8'h14;
  localparam logic [7:0] OFS_ST2P = 8'h18;
  localparam logic [7:0] OFS_ST3P = 8'h1C;
  localparam logic [7:0] OFS_ACC0 = 8'h20;
  localparam logic [7:0] OFS_ACC0H = 8'h24;
  localparam logic [7:0] OFS_AUX0 = 8'h40;
  localparam logic [7:0] OFS_BUSY = 8'h60;
  // ==========================================
  // status field positions
  localparam int B_OV2 = 15;
  localparam int B_OV3 = 14;
  localparam int B_TC1 = 13;
  localparam int B_TC2 = 12;
  localparam int B_CARRY = 11;
  localparam int B_OV0 = 10;
  localparam int B_OV1 = 9;
  localparam int B_LEGACY = 5;
  localparam int B_RDM = 10;
  localparam int B_CFRZ = 15;
  localparam int B_CEN = 14;
  localparam int B_CCLR = 13;
  localparam int B_MPMC = 6;
  // ==========================================
  // reset values, masks
  localparam logic [15:0] ST0_RST = 16'h3800;
  localparam logic [15:0] ST1_RST = 16'h2920;
  localparam logic [15:0] ST2_RST = 16'h1000;
  localparam logic [15:0] ST3_RST = 16'h1C00;
  localparam logic [15:0] ST2_WMASK = 16'hDDFF;
  localparam logic [15:0] ST3_WMASK = 16'hF0E7;
  localparam logic [15:0] ST3_RSV_VAL = 16'h0C00;
  localparam logic [15:0] PROT0 = 16'hE200;
  localparam logic [15:0] PROT1 = 16'h0420;
  localparam logic [15:0] PROT2 = 16'h0000;
  localparam logic [15:0] PROT3 = 16'hE0A0;
  // ==========================================
  // saturation values and rounding constants
  localparam logic [39:0] SAT_POS = 40'h007FFFFFFF;
  localparam logic [39:0] SAT_NEG = 40'hFF80000000;
  localparam logic [39:0] RND_ADD = 40'h0000008000;
  localparam logic [15:0] RND_HALF = 16'h8000;
  // ==========================================
  // timing
  localparam int FLUSH_CYC = 5;
  localparam logic [2:0] FLUSH_WAIT = 3'(FLUSH_CYC - 1);
  // ==========================================
  // instruction issue
  typedef enum logic [3:0] {
    DSBS_OP_SAT = 4'h1,
    DSBS_OP_SATRND = 4'h2,
    DSBS_OP_BIT_SET_INSTRUCTION_ACC = 4'h3,
    DSBS_OP_BIT_SET_INSTRUCTION_AUX = 4'h4,
    DSBS_OP_BIT_SET_INSTRUCTION_ST = 4'h5,
    DSBS_OP_SFTC = 4'h6
  } dsbs_op_t;
  typedef struct packed {
    logic valid;
    dsbs_op_t op;
    logic [1:0] src;
    logic [1:0] dst;
    logic [15:0] baddr;
    logic tc_sel;
    logic repeat_op;
  } dsbs_issue_t;
  typedef struct packed {
    logic accept;
    logic reject;
    logic flush;
    logic busy;
  } dsbs_resp_t;
  typedef enum logic [1:0] {
    DSBS_ST_IDLE = 2'b01,
    DSBS_ST_FLUSH = 2'b10
  } dsbs_state_t;
endpackage

//--- verilog/dsbs_core.sv
// Purpose: saturate with rounding, register bit set, status bit set, conditional shift
// Assumes: one instruction per cycle from the issue port, software view over APB
// Notes: four accumulators, eight aux/temp registers, four status words
// Operation
// RL1 - saturate detects overflow at bit 31 as 32-bit signed, ignoring wide mode
// RL2 - overflow loads 00 7FFF FFFFh positive or FF 8000 0000h negative
// RL3 - saturate overflow sets the destination accumulator overflow flag
// RL4 - saturate and its rounding leave the carry bit unchanged
// RL5 - applied rounding clears the sixteen low result bits
// RL6 - legacy compatibility mode rounds without clearing low bits
// RL7 - rounding mode zero adds 8000h unconditionally
// RL8 - rounding mode one rounds to nearest even
// RL9 - accumulator bit set uses six address bits, ignores addresses above 39
// RL10 - aux or temp bit set uses four address bits
// RL11 - register bit set alters no status bits
// RL12 - status bit set takes 1 cycle, cache bits flush and take 5
// RL13 - status bit set is refused as a repeated instruction
// RL14 - carry lives at bit 11 of status word zero and is settable
// RL15 - protected address ignores writes to protected bits and reads them as 0
// RL16 - software writes 1100b into reserved bits 11 to 8 of status word three
// RL17 - microprocessor mode bit reset value comes from sampled pins
// RL18 - no sign clash: shift left one and clear selected test flag
// RL19 - sign clash: keep accumulator and set selected test flag
// RL20 - accumulators are 40 bits with guard bits 39 to 32
// RL21 - status words reset to listed values, reserved bits stay fixed
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
module dsbs_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction issue
  input wire dsbs_pkg::dsbs_issue_t issue,
  output dsbs_pkg::dsbs_resp_t resp,
  // mode strap pin
  input wire logic mp_mode_pin,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import dsbs_pkg::*;

  // ==========================================
  // state
  logic [39:0] acc_r [4];
  logic [15:0] aux_r [8];
  logic [15:0] st_r [4];
  logic [15:0] st_nxt [4];
  logic [2:0] flush_cnt_r;
  dsbs_state_t state_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic strap_done_r;

  // overflow flag position for an accumulator index
  function automatic int ov_bit(input logic [1:0] idx);
    case (idx)
      2'd0: ov_bit = B_OV0;
      2'd1: ov_bit = B_OV1;
      2'd2: ov_bit = B_OV2;
      default: ov_bit = B_OV3;
    endcase
  endfunction

  // decode of an apb status offset, plain or protected
  function automatic logic st_hit(input logic [7:0] a, input logic [7:0] base);
    st_hit = (a[7:5] == 3'b000) && (a[3:0] == base[3:0]) && (a[1:0] == 2'b00);
  endfunction

  // ==========================================
  // issue handshake
  logic busy;
  logic go;
  logic st_cache_hit;
  assign busy = (state_r == DSBS_ST_FLUSH);
  assign go = issue.valid && !busy && !(issue.op == DSBS_OP_BIT_SET_INSTRUCTION_ST && issue.repeat_op); // RL13
  assign st_cache_hit = (issue.dst == 2'd3) &&
    (issue.baddr[3:0] inside {4'(B_CFRZ), 4'(B_CEN), 4'(B_CCLR)});
  assign resp.accept = go;
  assign resp.reject = issue.valid && !busy && !go; // RL13
  assign resp.flush = go && issue.op == DSBS_OP_BIT_SET_INSTRUCTION_ST && st_cache_hit; // RL12
  assign resp.busy = busy;

  // flush sequencer holds issue off for the remaining cycles
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= DSBS_ST_IDLE;
      flush_cnt_r <= 3'h0;
    end else begin
      case (state_r)
        DSBS_ST_IDLE: begin
          if (resp.flush) begin
            state_r <= DSBS_ST_FLUSH; // RL12
            flush_cnt_r <= FLUSH_WAIT;
          end
        end
        DSBS_ST_FLUSH: begin
          flush_cnt_r <= flush_cnt_r - 3'h1;
          if (flush_cnt_r == 3'h1) begin
            state_r <= DSBS_ST_IDLE;
          end
        end
        default: state_r <= DSBS_ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // saturate datapath
  logic [39:0] src_acc;
  logic [39:0] sum;
  logic [39:0] sat_res;
  logic rnd_do;
  logic sat_ovf;
  logic rnd_req;
  assign src_acc = acc_r[issue.src];
  assign rnd_req = (issue.op == DSBS_OP_SATRND);

  // rounding decision and saturation
  always_comb begin
    rnd_do = 1'b0;
    if (rnd_req) begin
      if (!st_r[2][B_RDM]) begin
        rnd_do = 1'b1; // RL7
      end else if (src_acc[15:0] > RND_HALF) begin
        rnd_do = 1'b1; // RL8
      end else if (src_acc[15:0] == RND_HALF) begin
        rnd_do = src_acc[16]; // RL8
      end
    end
    sum = rnd_do ? src_acc + RND_ADD : src_acc; // RL4
    if (rnd_do && !st_r[1][B_LEGACY]) begin
      sum[15:0] = 16'h0000; // RL5 RL6
    end
    // frame overflow when guard bits disagree with bit 31
    sat_ovf = (sum[39:31] != {9{sum[39]}}); // RL1
    if (sat_ovf) begin
      sat_res = sum[39] ? SAT_NEG : SAT_POS; // RL2
    end else begin
      sat_res = sum;
    end
  end

  // ==========================================
  // conditional shift
  logic sft_clash;
  logic [39:0] sft_res;
  assign sft_clash = acc_r[issue.dst][31] ^ acc_r[issue.dst][30];
  assign sft_res = sft_clash ? acc_r[issue.dst] : {acc_r[issue.dst][38:0], 1'b0}; // RL18 RL19

  // ==========================================
  // apb decode
  logic apb_wr;
  logic [1:0] st_idx;
  logic st_sel;
  logic st_prot;
  logic [15:0] prot_mask [4];
  assign prot_mask[0] = PROT0;
  assign prot_mask[1] = PROT1;
  assign prot_mask[2] = PROT2;
  assign prot_mask[3] = PROT3;
  assign apb_wr = psel && penable && pwrite;
  assign st_idx = paddr[3:2];
  assign st_sel = st_hit(paddr, {4'h0, paddr[3:2], 2'b00});
  assign st_prot = paddr[4];
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ==========================================
  // accumulators: saturate, bit set, shift, apb write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        acc_r[i] <= 40'h0000000000; // RL20
      end
    end else begin
      if (go && (issue.op == DSBS_OP_SAT || issue.op == DSBS_OP_SATRND)) begin
        acc_r[issue.dst] <= sat_res;
      end else if (go && issue.op == DSBS_OP_BIT_SET_INSTRUCTION_ACC) begin
        if (issue.baddr[5:0] < 6'd40) begin
          acc_r[issue.dst][issue.baddr[5:0]] <= 1'b1; // RL9 RL11
        end
      end else if (go && issue.op == DSBS_OP_SFTC) begin
        acc_r[issue.dst] <= sft_res; // RL18 RL19
      end else if (apb_wr && paddr[7:5] == 3'b001) begin
        if (paddr[2]) begin
          acc_r[paddr[4:3]][39:32] <= pwdata[7:0];
        end else begin
          acc_r[paddr[4:3]][31:0] <= pwdata;
        end
      end
    end
  end

  // aux and temp registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        aux_r[i] <= 16'h0000;
      end
    end else begin
      if (go && issue.op == DSBS_OP_BIT_SET_INSTRUCTION_AUX) begin
        aux_r[{issue.src[0], issue.dst}][issue.baddr[3:0]] <= 1'b1; // RL10 RL11
      end else if (apb_wr && paddr[7:5] == 3'b010) begin
        aux_r[paddr[4:2]] <= pwdata[15:0];
      end
    end
  end

  // ==========================================
  // status words
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      st_nxt[i] = st_r[i];
    end
    // software write first so instruction events win
    if (apb_wr && st_sel) begin
      if (st_prot) begin
        st_nxt[st_idx] = (st_r[st_idx] & prot_mask[st_idx]) |
          (pwdata[15:0] & ~prot_mask[st_idx]); // RL15
      end else begin
        st_nxt[st_idx] = pwdata[15:0]; // RL16
      end
    end
    if (go && issue.op == DSBS_OP_BIT_SET_INSTRUCTION_ST) begin
      st_nxt[issue.dst][issue.baddr[3:0]] = 1'b1; // RL12 RL14
    end
    if (go && (issue.op == DSBS_OP_SAT || issue.op == DSBS_OP_SATRND) && sat_ovf) begin
      st_nxt[0][ov_bit(issue.dst)] = 1'b1; // RL3
    end
    if (go && issue.op == DSBS_OP_SFTC) begin
      st_nxt[0][issue.tc_sel ? B_TC2 : B_TC1] = sft_clash; // RL18 RL19
    end
    // reserved positions held
    st_nxt[2] = st_nxt[2] & ST2_WMASK; // RL21
    st_nxt[3] = (st_nxt[3] & ST3_WMASK) | ST3_RSV_VAL; // RL21
  end

  // status registers, mode bit caught from the strap after release
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r[0] <= ST0_RST; // RL21
      st_r[1] <= ST1_RST;
      st_r[2] <= ST2_RST;
      st_r[3] <= ST3_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        st_r[i] <= st_nxt[i];
      end
      if (!strap_done_r) begin
        st_r[3][B_MPMC] <= pin_s2_r; // RL17
      end
    end
  end

  // strap synchroniser, free running so the pin is settled when reset lifts
  always_ff @(posedge clk) begin
    pin_s1_r <= mp_mode_pin;
    pin_s2_r <= pin_s1_r; // RL17
  end

  // one-shot capture flag, cleared by every reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
    end else begin
      strap_done_r <= 1'b1;
    end
  end

  // ==========================================
  // apb read data
  always_comb begin
    prdata = 32'h00000000;
    if (st_sel) begin
      if (st_prot) begin
        prdata = {16'h0000, st_r[st_idx] & ~prot_mask[st_idx]}; // RL15
      end else begin
        prdata = {16'h0000, st_r[st_idx]};
      end
    end else if (paddr[7:5] == 3'b001 && paddr[1:0] == 2'b00) begin
      prdata = paddr[2] ? {24'h000000, acc_r[paddr[4:3]][39:32]} : acc_r[paddr[4:3]][31:0];
    end else if (paddr[7:5] == 3'b010 && paddr[1:0] == 2'b00) begin
      prdata = {16'h0000, aux_r[paddr[4:2]]};
    end else if (paddr == OFS_BUSY) begin
      prdata = {29'h0, flush_cnt_r};
    end
  end
endmodule // dsbs_core

//--- tb/dsbs_props.sv
// Purpose: assertions on the issue, response and apb read ports
// Assumes: resp is combinational on issue
// Notes: bound into every dsbs_core
`timescale 1ns/1ps
// ==========================================
// checker
module dsbs_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // issue side
  input wire dsbs_pkg::dsbs_issue_t issue,
  input wire dsbs_pkg::dsbs_resp_t resp,
  // apb read side
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata
);
  import dsbs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // request decodes
  wire logic st_req = issue.valid && issue.op == DSBS_OP_BIT_SET_INSTRUCTION_ST;
  wire logic rd = psel && !pwrite;
  // issue handling
  a_repeat_refused: assert property (st_req && issue.repeat_op && !resp.busy |->
    resp.reject && !resp.accept) else $error("repeated status set taken");
  a_busy_blocks: assert property (resp.busy |-> !resp.accept)
    else $error("issue taken while busy");
  a_flush_span: assert property (resp.flush |=> resp.busy [*4] ##1 !resp.busy)
    else $error("flush busy length wrong");
  a_cache_flush: assert property (resp.accept && st_req && issue.dst == 2'd3 &&
    issue.baddr[3:0] >= 4'hD |-> resp.flush) else $error("cache bit set without flush");
  a_plain_set: assert property (resp.accept && st_req && issue.baddr[3:0] < 4'hD
    |-> !resp.flush) else $error("plain status set flushed");
  // protected and reserved views
  a_prot_zero: assert property (rd && paddr == OFS_ST0P |->
    (prdata[15:0] & PROT0) == 16'h0000) else $error("protected word0 bits read nonzero");
  a_prot_three: assert property (rd && paddr == OFS_ST3P |->
    (prdata[15:0] & PROT3) == 16'h0000) else $error("protected word3 bits read nonzero");
  a_rsv_fixed: assert property (rd && paddr == OFS_ST3 |-> prdata[11:8] == 4'hC)
    else $error("word3 reserved field wrong");
endmodule // dsbs_props

bind dsbs_core dsbs_props u_props (.clk(clk), .rst_n(rst_n), .issue(issue), .resp(resp),
  .psel(psel), .pwrite(pwrite), .paddr(paddr), .prdata(prdata));

//--- tb/dsp_saturate_bitset_status_tb_top.sv
// Purpose: self-checking bench for saturate, bit set, status set and shift
// Assumes: zero wait apb, results readable next cycle
// Notes: random values from a fixed seed plus corner cases
`timescale 1ns/1ps
// ==========================================
// bench top
module dsp_saturate_bitset_status_tb_top;
  import dsbs_pkg::*;
  logic clk = 0, rst_n = 0, mp_mode_pin = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  dsbs_issue_t issue = '0;
  dsbs_resp_t resp;
  int n_fail = 0, total_checks = 0, cyc = 0;
  int bl [5] = '{0, 31, 39, 40, 63};
  logic [15:0] rv [4] = '{ST0_RST, ST1_RST, ST2_RST, ST3_RST | 16'h0040};
  logic [15:0] pv [4] = '{PROT0, PROT1, PROT2, PROT3};
  logic [39:0] cv [4] = '{40'h007FFF8000, 40'hEF0FF08023, 40'h0000018000, 40'h0000028000};
  always #25 clk = ~clk;
  dsbs_core dut (.clk(clk), .rst_n(rst_n), .issue(issue), .resp(resp),
    .mp_mode_pin(mp_mode_pin), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // compare and report
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // apb master transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    chk(40'(pslverr), 40'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [39:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(40'(r), e);
  endtask
  task automatic wacc(input int n, input logic [39:0] v);
    wr(OFS_ACC0 + 8'(8 * n), v[31:0]);
    wr(OFS_ACC0H + 8'(8 * n), {24'h0, v[39:32]});
  endtask
  task automatic racc(input int n, input logic [39:0] e);
    logic [31:0] lo, hi;
    apb(1'b0, OFS_ACC0 + 8'(8 * n), 32'h0, lo);
    apb(1'b0, OFS_ACC0H + 8'(8 * n), 32'h0, hi);
    chk({hi[7:0], lo}, e);
  endtask
  // one instruction, response sampled mid cycle
  task automatic iss(input dsbs_op_t op, input logic [1:0] s, input logic [1:0] d,
    input logic [15:0] b, input logic tc, input logic rp, output dsbs_resp_t r);
    issue <= '{1'b1, op, s, d, b, tc, rp};
    @(negedge clk);
    r = resp;
    @(posedge clk);
    issue.valid <= 1'b0;
    @(posedge clk);
  endtask
  // expected saturate result
  function automatic logic [39:0] sat_f(input logic [39:0] v, input logic rnd,
    input logic rounding_mode_bit, input logic leg, output logic ov);
    logic [39:0] w;
    logic add;
    add = rnd && (!rounding_mode_bit || v[15:0] > RND_HALF || (v[15:0] == RND_HALF && v[16]));
    w = add ? v + RND_ADD : v;
    if (rnd && !leg) w[15:0] = 16'h0000;
    ov = w[39:31] != {9{w[31]}};
    return ov ? (w[39] ? SAT_NEG : SAT_POS) : w;
  endfunction
  // cycle ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end
  // main sequence
  initial begin
    dsbs_resp_t r;
    logic [39:0] v, e;
    logic [15:0] c, s0, s1, s2, sel;
    logic ov, rnd, x;
    int b, n;
    void'($urandom(10));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      rchk(OFS_ST0 + 8'(4 * i), {24'h0, rv[i]});
      rchk(OFS_ST0P + 8'(4 * i), {24'h0, rv[i] & ~pv[i]});
    end
    rchk(8'h70, 40'h0);
    for (int i = 0; i < 40; i++) begin
      v = (i < 4) ? cv[i] : 40'({$urandom, $urandom});
      c = 16'($urandom);
      rnd = c[3] | (i < 4);
      s0 = {c[15:10], 10'h0};
      s1 = {ST1_RST[15:11], c[1], ST1_RST[9:6], c[2] & (i > 3), ST1_RST[4:0]};
      s2 = ST2_RST | {5'h0, c[0], 10'h0};
      wr(OFS_ST0, {16'h0, s0});
      wr(OFS_ST1, {16'h0, s1});
      wr(OFS_ST2, {16'h0, s2});
      wacc(0, v);
      e = sat_f(v, rnd, s2[10], s1[5], ov);
      iss(rnd ? DSBS_OP_SATRND : DSBS_OP_SAT, 2'd0, 2'd1, 16'h0, 1'b0, 1'b0, r);
      racc(1, e);
      rchk(OFS_ST0, {24'h0, s0 | {6'h0, ov, 9'h0}});
    end
    wr(OFS_ST0, 32'h5A00);
    for (int i = 0; i < 8; i++) begin
      b = (i < 5) ? bl[i] : $urandom_range(63);
      v = 40'({$urandom, $urandom});
      wacc(2, v);
      iss(DSBS_OP_BIT_SET_INSTRUCTION_ACC, 2'd0, 2'd2, {10'($urandom), 6'(b)}, 1'b0, 1'b0, r);
      racc(2, (b < 40) ? v | (40'h1 << b) : v);
      b = $urandom;
      wr(OFS_AUX0 + 8'(4 * i), 32'h0);
      iss(DSBS_OP_BIT_SET_INSTRUCTION_AUX, {1'b0, i[2]}, i[1:0], 16'(b), 1'b0, 1'b0, r);
      rchk(OFS_AUX0 + 8'(4 * i), {24'h0, 16'h1 << b[3:0]});
    end
    rchk(OFS_ST0, 40'h5A00);
    wr(OFS_ST0, 32'h0);
    iss(DSBS_OP_BIT_SET_INSTRUCTION_ST, 2'd0, 2'd0, 16'd11, 1'b0, 1'b0, r);
    chk(r.accept, 1'b1);
    rchk(OFS_ST0, 40'h0800);
    iss(DSBS_OP_BIT_SET_INSTRUCTION_ST, 2'd0, 2'd0, 16'd3, 1'b0, 1'b1, r);
    chk(r.reject, 1'b1);
    chk(r.accept, 1'b0);
    rchk(OFS_ST0, 40'h0800);
    for (int i = 0; i < 16; i++) begin
      v = 40'({$urandom, $urandom});
      x = v[31] ^ v[30];
      sel = 16'h2000 >> i[0];
      wr(OFS_ST0, x ? 32'h0 : 32'h3000);
      wacc(3, v);
      iss(DSBS_OP_SFTC, 2'd0, 2'd3, 16'h0, i[0], 1'b0, r);
      racc(3, x ? v : v << 1);
      rchk(OFS_ST0, {24'h0, x ? sel : 16'h3000 ^ sel});
    end
    wacc(3, 40'h0);
    for (int k = 13; k < 16; k++) begin
      issue <= '{1'b1, DSBS_OP_BIT_SET_INSTRUCTION_ST, 2'd0, 2'd3, 16'(k), 1'b0, 1'b0};
      @(negedge clk);
      chk(resp.flush, 1'b1);
      @(posedge clk);
      issue <= '{1'b1, DSBS_OP_BIT_SET_INSTRUCTION_ACC, 2'd0, 2'd3, 16'd0, 1'b0, 1'b0};
      n = 0;
      for (int i = 0; i < 6; i++) begin
        @(negedge clk);
        n += (resp.busy === 1'b1 && resp.accept === 1'b0);
        @(posedge clk);
        if (i == 2) issue.valid <= 1'b0;
      end
      chk(40'(n), 40'd4);
    end
    racc(3, 40'h0);
    rchk(OFS_ST3, 40'hFC40);
    // second reset with the strap low
    mp_mode_pin <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(OFS_ST3, {24'h0, ST3_RST});
    rchk(OFS_ST0, {24'h0, ST0_RST});
    racc(2, 40'h0);
    stop_test;
  end
endmodule // dsp_saturate_bitset_status_tb_top
